// File: hw/regdvs_consts.svh
`ifndef REGDVS_CONSTS_SVH
`define REGDVS_CONSTS_SVH


// Register offsets
`define OFS_ALT0      8'h3B
`define OFS_ALT1      8'h3C
`define OFS_ALT2      8'h3D
`define OFS_ALT3      8'h3E
`define OFS_SERIAL    8'h3F
`define OFS_BB_ENA    8'h40
`define OFS_BB_CFG    8'h41

// Field positions in the buck-boost config register; SEQ bits are the boot slot field of the enable register
`define BIT_TABLE_OFF 7
`define BIT_SLOW      4
`define BIT_ACT_DSC   3
`define BIT_RAMP      2
`define BIT_BUCK_ONLY 1
`define BIT_PSV_DSC   0
`define SEQ_MSB       7
`define SEQ_LSB       5

// Encodings
`define PAIR_OFF      5'h00
`define PAIR_SERIAL   5'h1D
`define SLOT_OFF      3'h0
`define SLOT_AT_0     3'h2
`define SLOT_AT_25    3'h3
`define SLOT_AT_50    3'h4
`define SLOT_SW       3'h7
`define EN_OFF        2'h0
`define EN_ON         2'h1
`define EN_PINS       2'h2

// Reset values
`define RST_CODE      6'h00
`define RST_EN        2'h0

// Timing
`define CLK_PERIOD_NS 40
`define RAMP_STEP_NS  20000
`define RAMP_TICKS    (`RAMP_STEP_NS / `CLK_PERIOD_NS)

`endif

// File: hw/regdvs_pkg.sv
package regdvs_pkg;

  typedef logic [5:0] code_t;

  typedef enum logic [1:0] {
    RAMP_IDLE = 2'b01,
    RAMP_WAIT = 2'b10
  } ramp_state_e;

  typedef struct packed {
    ramp_state_e st;
    code_t       code;
    logic [8:0]  cnt;
  } ramp_s;

  typedef struct packed {
    logic [3:0][5:0] alt_voltage_code;
    code_t           serial_voltage_readback;
    logic [2:0]      bb_boot_slot;
    logic            slot_held;
    logic [1:0]      bb_enable_source;
    logic            bb_table_current_off;
    logic            bb_slow_edges;
    logic            bb_active_discharge;
    logic            bb_voltage_ramp;
    logic            bb_buck_only_select;
    logic            bb_passive_discharge;
    code_t           target;
    logic            bb_on;
    logic            act_out;
    logic            psv_out;
    logic [7:0]      rdata;
  } regs_s;

endpackage

// File: hw/pin_pair_decode.sv
`timescale 1ns/1ps
`include "regdvs_consts.svh"

module pin_pair_decode (
  // Selection
  input  wire logic [4:0] pair_select,
  input  wire logic [7:0] pins,
  // Result
  output logic [1:0]      pin_state,
  output logic            pair_ok,
  output logic            serial_mode
);
  import regdvs_pkg::*;

  // Codes 1..28 walk the pin pairs in ascending order, first pin is the MSB
  function automatic logic [5:0] pair_of(input logic [4:0] code);
    logic [4:0] n;
    logic [5:0] r;
    n = 5'h01;
    r = 6'h00;
    for (int i = 0; i < 7; i++) begin
      for (int j = i + 1; j < 8; j++) begin
        if (n == code) begin
          r = {3'(i), 3'(j)};
        end
        n = n + 5'h01;
      end
    end
    return r;
  endfunction

  logic [5:0] pr;

  always_comb begin
    pr          = pair_of(pair_select);
    serial_mode = (pair_select == `PAIR_SERIAL);
    pair_ok     = (pair_select != `PAIR_OFF) && (pair_select < `PAIR_SERIAL);
    pin_state   = {pins[pr[5:3]], pins[pr[2:0]]};
  end

endmodule

// File: hw/voltage_ramp.sv
`timescale 1ns/1ps
`include "regdvs_consts.svh"

module voltage_ramp (
  // Clock and reset
  input  wire logic           clk,
  input  wire logic           reset_n,
  // Setting
  input  wire logic           ramp_en,
  input  wire regdvs_pkg::code_t setting,
  // Applied code
  output regdvs_pkg::code_t   code
);
  import regdvs_pkg::*;

  localparam logic [8:0] TICK_LAST = 9'(`RAMP_TICKS - 1);

  ramp_s q;
  ramp_s d;

  always_comb begin
    d = q;
    // Falls and disabled ramping jump at once; only rises are paced
    if (!ramp_en || (setting <= q.code)) begin
      d.code = setting;
      d.st   = RAMP_IDLE;
      d.cnt  = 9'h000;
    end else begin
      case (q.st)
        RAMP_IDLE: begin
          d.st  = RAMP_WAIT;
          d.cnt = 9'h000;
        end
        RAMP_WAIT: begin
          if (q.cnt == TICK_LAST) begin
            d.code = q.code + 6'h01;
            d.cnt  = 9'h000;
          end else begin
            d.cnt = q.cnt + 9'h001;
          end
        end
        default: d.st = RAMP_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '{st: RAMP_IDLE, code: `RST_CODE, cnt: 9'h000};
    end else begin
      q <= d;
    end
  end

  assign code = q.code;

  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_rise;
    ramp_en && (setting > code);
  endsequence

  ramp_one_step_a: assert property (s_rise |=> code <= $past(code) + 6'h01)
    else $error("ramp rose by more than one step");
  // Keyed on the previous enable, so a jump made just before ramping starts is not a step
  ramp_paced_a: assert property (($past(ramp_en) && code > $past(code)) |-> $past(q.cnt) == TICK_LAST)
    else $error("ramp step came before its interval");

endmodule

// File: hw/regulator_dvs_and_enable_regs.sv
`timescale 1ns/1ps
`include "regdvs_consts.svh"

module regulator_dvs_and_enable_regs (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              reset_n,

  // Register port
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  output logic [7:0]             reg_rdata,

  // Control pins and their selection
  input  wire logic [7:0]        multipurpose_control_pin,
  input  wire logic [4:0]        scaling_pin_pair_select,
  input  wire logic [7:0]        bb_pin_enable_mask,

  // Step-down voltage sources
  input  wire logic              serial_code_valid,
  input  wire regdvs_pkg::code_t serial_code,
  input  wire regdvs_pkg::code_t stepdown_base_code,

  // Boot progress and power state
  input  wire logic [2:0]        bb_boot_slot_strap,
  input  wire logic              boot_started,
  input  wire logic              boot_quarter,
  input  wire logic              boot_half,
  input  wire logic              boot_done,
  input  wire logic              hard_reset,
  input  wire logic              power_off,
  input  wire regdvs_pkg::code_t bb_voltage_setting,

  // Step-down control
  output regdvs_pkg::code_t      stepdown_target,

  // Buck-boost control
  output logic                   bb_enable,
  output logic                   bb_active_discharge_on,
  output logic                   bb_passive_discharge_on,
  output logic                   bb_slow_edges_on,
  output logic                   bb_buck_only_on,
  output logic                   bb_table_current_off_on,
  output regdvs_pkg::code_t      bb_applied_code
);
  import regdvs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin pair decode

  logic [1:0] pin_state;
  logic       pair_ok;
  logic       serial_mode;
  logic       pins_request;

  pin_pair_decode pin_pair_decode_inst (
    .pair_select (scaling_pin_pair_select),
    .pins        (multipurpose_control_pin),
    .pin_state   (pin_state),
    .pair_ok     (pair_ok),
    .serial_mode (serial_mode)
  );

  // Several selected pins act as a logical OR
  assign pins_request = |(multipurpose_control_pin & bb_pin_enable_mask);

  ////////////////////////////////////////////////////////////////////////////////
  // State

  regs_s q;
  regs_s d;

  always_comb begin
    d = q;

    // Boot slot is a strap, caught on the first edge after reset release
    if (!q.slot_held) begin
      d.bb_boot_slot = bb_boot_slot_strap;
      d.slot_held    = 1'b1;
    end

    // Readback follows the serial path only; bus writes never reach it
    if (serial_code_valid) begin
      d.serial_voltage_readback = serial_code;
    end

    // Register writes; unused bits are simply not stored
    if (reg_wr) begin
      case (reg_addr)
        `OFS_ALT0: begin
          d.alt_voltage_code[0] = reg_wdata[5:0];
        end
        `OFS_ALT1: begin
          d.alt_voltage_code[1] = reg_wdata[5:0];
        end
        `OFS_ALT2: begin
          d.alt_voltage_code[2] = reg_wdata[5:0];
        end
        `OFS_ALT3: begin
          d.alt_voltage_code[3] = reg_wdata[5:0];
        end
        `OFS_BB_ENA: begin
          d.bb_enable_source = reg_wdata[1:0];
        end
        `OFS_BB_CFG: begin
          d.bb_table_current_off = reg_wdata[`BIT_TABLE_OFF];
          d.bb_slow_edges        = reg_wdata[`BIT_SLOW];
          d.bb_active_discharge  = reg_wdata[`BIT_ACT_DSC];
          d.bb_voltage_ramp      = reg_wdata[`BIT_RAMP];
          d.bb_buck_only_select  = reg_wdata[`BIT_BUCK_ONLY];
          d.bb_passive_discharge = reg_wdata[`BIT_PSV_DSC];
        end
        default: begin
        end
      endcase
    end

    // Step-down target, registered so a pin change lands on the next edge
    if (serial_mode) begin
      d.target = q.serial_voltage_readback;
    end else if (pair_ok) begin
      case (pin_state)
        2'b00: d.target = q.alt_voltage_code[0];
        2'b01: d.target = q.alt_voltage_code[1];
        2'b10: d.target = q.alt_voltage_code[2];
        2'b11: d.target = q.alt_voltage_code[3];
        default: d.target = q.alt_voltage_code[0];
      endcase
    end else begin
      d.target = stepdown_base_code;
    end

    // Buck-boost enable; reserved slot and source codes leave it off
    d.bb_on = 1'b0;
    if (q.slot_held && !hard_reset && !power_off) begin
      case (q.bb_boot_slot)
        `SLOT_AT_0: d.bb_on = boot_started;
        `SLOT_AT_25: d.bb_on = boot_quarter;
        `SLOT_AT_50: d.bb_on = boot_half;
        `SLOT_SW: begin
          // Enable field only counts once the boot delay is over
          if (boot_done) begin
            case (q.bb_enable_source)
              `EN_ON: d.bb_on = 1'b1;
              `EN_PINS: d.bb_on = pins_request;
              default: d.bb_on = 1'b0;
            endcase
          end
        end
        default: d.bb_on = 1'b0;
      endcase
    end

    // Discharge paths; hard reset forces both on, power off forces only the active one
    d.act_out = hard_reset || power_off || (d.bb_active_discharge && !d.bb_on);
    d.psv_out = hard_reset || (d.bb_passive_discharge && !d.bb_on);

    // Read data is captured on the read strobe and held until the next one
    if (reg_rd) begin
      case (reg_addr)
        `OFS_ALT0: d.rdata = {2'b00, q.alt_voltage_code[0]};
        `OFS_ALT1: d.rdata = {2'b00, q.alt_voltage_code[1]};
        `OFS_ALT2: d.rdata = {2'b00, q.alt_voltage_code[2]};
        `OFS_ALT3: d.rdata = {2'b00, q.alt_voltage_code[3]};
        `OFS_SERIAL: d.rdata = {2'b00, q.serial_voltage_readback};
        `OFS_BB_ENA: d.rdata = {q.bb_boot_slot, 3'b000, q.bb_enable_source};
        `OFS_BB_CFG: begin
          d.rdata = {q.bb_table_current_off, 2'b00, q.bb_slow_edges,
                     q.bb_active_discharge, q.bb_voltage_ramp,
                     q.bb_buck_only_select, q.bb_passive_discharge};
        end
        default: d.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '{
        alt_voltage_code:        {4{`RST_CODE}},
        serial_voltage_readback: `RST_CODE,
        bb_boot_slot:            `SLOT_OFF,
        slot_held:               1'b0,
        bb_enable_source:        `RST_EN,
        bb_table_current_off:    1'b0,
        bb_slow_edges:           1'b0,
        bb_active_discharge:     1'b0,
        bb_voltage_ramp:         1'b0,
        bb_buck_only_select:     1'b0,
        bb_passive_discharge:    1'b0,
        target:                  `RST_CODE,
        bb_on:                   1'b0,
        act_out:                 1'b1,
        psv_out:                 1'b1,
        rdata:                   8'h00
      };
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Voltage ramp

  // Ramp paces only the buck-boost setting; the step-down codes jump
  voltage_ramp voltage_ramp_inst (
    .clk     (clk),
    .reset_n (reset_n),
    .ramp_en (q.bb_voltage_ramp),
    .setting (bb_voltage_setting),
    .code    (bb_applied_code)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign reg_rdata               = q.rdata;
  assign stepdown_target         = q.target;
  assign bb_enable               = q.bb_on;
  assign bb_active_discharge_on  = q.act_out;
  assign bb_passive_discharge_on = q.psv_out;
  assign bb_slow_edges_on        = q.bb_slow_edges;
  assign bb_buck_only_on         = q.bb_buck_only_select;
  assign bb_table_current_off_on = q.bb_table_current_off;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_pair(logic [1:0] st);
    pair_ok && !serial_mode && (pin_state == st);
  endsequence

  property p_pick(logic [1:0] st, code_t alt);
    s_pair(st) |=> stepdown_target == $past(alt);
  endproperty

  pick_alt_zero_a: assert property (p_pick(2'b00, q.alt_voltage_code[0]))
    else $error("state 00 did not select code 0");
  pick_alt_one_a: assert property (p_pick(2'b01, q.alt_voltage_code[1]))
    else $error("state 01 did not select code 1");
  pick_alt_two_a: assert property (p_pick(2'b10, q.alt_voltage_code[2]))
    else $error("state 10 did not select code 2");
  pick_alt_three_a: assert property (p_pick(2'b11, q.alt_voltage_code[3]))
    else $error("state 11 did not select code 3");

  readback_kept_a: assert property (
    (reg_wr && reg_addr == `OFS_SERIAL && !serial_code_valid)
      |=> $stable(q.serial_voltage_readback))
    else $error("write changed serial readback");

  sequence s_on_ok;
    q.slot_held && !hard_reset && !power_off;
  endsequence

  quarter_slot_a: assert property (
    (s_on_ok and (q.bb_boot_slot == `SLOT_AT_25) && boot_quarter) |=> bb_enable)
    else $error("slot 011 did not enable at quarter boot");
  sw_enable_a: assert property (
    (s_on_ok and (q.bb_boot_slot == `SLOT_SW) && boot_done && q.bb_enable_source == `EN_ON)
      |=> bb_enable)
    else $error("enable field 01 did not enable after boot");
  field_ignored_a: assert property (
    (q.slot_held && !(q.bb_boot_slot inside {`SLOT_AT_0, `SLOT_AT_25, `SLOT_AT_50, `SLOT_SW}))
      |=> !bb_enable)
    else $error("enable field acted outside slot 111");

  act_discharge_a: assert property (
    (!bb_enable && q.bb_active_discharge) |-> bb_active_discharge_on)
    else $error("disabled converter not actively discharged");
  psv_discharge_a: assert property (
    (!bb_enable && q.bb_passive_discharge) |-> bb_passive_discharge_on)
    else $error("disabled converter not passively discharged");

  unused_zero_a: assert property (
    (reg_rd && reg_addr >= `OFS_ALT0 && reg_addr <= `OFS_SERIAL)
      |=> reg_rdata[7:6] == 2'b00)
    else $error("unused code bits read nonzero");

  ////////////////////////////////////////////////////////////////////////////////
  // Checks on enable source, discharge, config and scaling path

  // Slot 111 with the boot delay over and nothing forcing the converter off
  sequence s_sw_ready;
    s_on_ok ##0 ((q.bb_boot_slot == `SLOT_SW) && boot_done);
  endsequence

  zero_slot_a: assert property (
    (s_on_ok ##0 ((q.bb_boot_slot == `SLOT_AT_0) && boot_started)) |=> bb_enable)
    else $error("slot 010 did not enable at boot start");
  half_slot_a: assert property (
    (s_on_ok ##0 ((q.bb_boot_slot == `SLOT_AT_50) && boot_half)) |=> bb_enable)
    else $error("slot 100 did not enable at half boot");
  slot_ro_a: assert property (
    (reg_wr && reg_addr == `OFS_BB_ENA && q.slot_held) |=> $stable(q.bb_boot_slot))
    else $error("bus write changed boot slot");

  boot_wait_a: assert property (
    (s_on_ok ##0 ((q.bb_boot_slot == `SLOT_SW) && !boot_done)) |=> !bb_enable)
    else $error("enable field acted before boot delay ended");
  pins_govern_a: assert property (
    (s_sw_ready ##0 (q.bb_enable_source == `EN_PINS)) |=> bb_enable == $past(pins_request))
    else $error("enable field 10 did not follow selected pins");
  source_reserved_a: assert property (
    (s_sw_ready ##0 (q.bb_enable_source == 2'h3)) |=> !bb_enable)
    else $error("reserved enable field turned converter on");
  source_off_a: assert property (
    (s_sw_ready ##0 (q.bb_enable_source == `EN_OFF))
      |=> !bb_enable && (bb_active_discharge_on == q.bb_active_discharge))
    else $error("enable field 00 misdrove enable or active discharge");

  reset_discharge_a: assert property (
    hard_reset |=> bb_active_discharge_on && bb_passive_discharge_on && !bb_enable)
    else $error("hard reset did not discharge and disable");
  act_follows_a: assert property (
    (!hard_reset && !power_off)
      |=> bb_active_discharge_on == (q.bb_active_discharge && !bb_enable))
    else $error("active discharge did not follow its bit and enable");
  psv_follows_a: assert property (
    !hard_reset |=> bb_passive_discharge_on == (q.bb_passive_discharge && !bb_enable))
    else $error("passive discharge did not follow its bit and enable");

  table_bit_a: assert property (
    (reg_wr && reg_addr == `OFS_BB_CFG)
      |=> bb_table_current_off_on == $past(reg_wdata[`BIT_TABLE_OFF]))
    else $error("peak current source bit not applied");
  slow_bit_a: assert property (
    (reg_wr && reg_addr == `OFS_BB_CFG) |=> bb_slow_edges_on == $past(reg_wdata[`BIT_SLOW]))
    else $error("slow edge bit not applied");

  serial_path_a: assert property (
    serial_mode |=> stepdown_target == $past(q.serial_voltage_readback))
    else $error("serial mode did not take the readback code");
  scaling_off_a: assert property (
    (!serial_mode && !pair_ok) |=> stepdown_target == $past(stepdown_base_code))
    else $error("disabled scaling did not take the base code");
  readback_load_a: assert property (
    serial_code_valid |=> q.serial_voltage_readback == $past(serial_code))
    else $error("serial code not captured in readback");

  unused_ctrl_a: assert property (
    (reg_rd && reg_addr == `OFS_BB_ENA) |=> reg_rdata[4:2] == 3'h0)
    else $error("unused enable register bits read nonzero");
  unused_cfg_a: assert property (
    (reg_rd && reg_addr == `OFS_BB_CFG) |=> reg_rdata[6:5] == 2'h0)
    else $error("unused config bits read nonzero");

endmodule

// File: tb/tb_regulator_dvs_and_enable_regs.sv
`timescale 1ns/1ps
`include "regdvs_consts.svh"

module tb_regulator_dvs_and_enable_regs;
  import regdvs_pkg::*;

  logic       clk;
  logic       reset_n;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic [7:0] pins;
  logic [4:0] pair_sel;
  logic [7:0] mask;
  logic       ser_valid;
  code_t      ser_code;
  code_t      base_code;
  logic [2:0] strap;
  logic [3:0] boot;
  logic       hard_reset;
  logic       power_off;
  code_t      bb_set;
  code_t      target;
  logic       bb_en;
  logic       act;
  logic       psv;
  logic       slow;
  logic       buck;
  logic       tbl;
  code_t      applied;
  int         err_count;
  int         n_compared;

  regulator_dvs_and_enable_regs regulator_dvs_and_enable_regs_inst (
    .clk(clk), .reset_n(reset_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .multipurpose_control_pin(pins), .scaling_pin_pair_select(pair_sel),
    .bb_pin_enable_mask(mask), .serial_code_valid(ser_valid),
    .serial_code(ser_code), .stepdown_base_code(base_code),
    .bb_boot_slot_strap(strap), .boot_started(boot[0]), .boot_quarter(boot[1]),
    .boot_half(boot[2]), .boot_done(boot[3]), .hard_reset(hard_reset),
    .power_off(power_off), .bb_voltage_setting(bb_set), .stepdown_target(target),
    .bb_enable(bb_en), .bb_active_discharge_on(act), .bb_passive_discharge_on(psv),
    .bb_slow_edges_on(slow), .bb_buck_only_on(buck), .bb_table_current_off_on(tbl),
    .bb_applied_code(applied));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t got %0h expected %0h", $time, got, exp);
    end
  endtask

  // All drivers start and end on a falling edge; the idle cycle at the end keeps
  // back-to-back calls from touching a strobe twice in one time step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    @(negedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    chk(reg_rdata, exp);
    @(negedge clk);
  endtask

  task automatic do_reset(input logic [2:0] s);
    reset_n = 1'b0;
    strap = s;
    repeat (5) @(negedge clk);
    chk({2'h0, target}, 8'h00);
    chk(reg_rdata, 8'h00);
    reset_n = 1'b1;
    @(negedge clk);
  endtask

  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    for (int i = 0; i < 4; i++) begin
      rd(8'(8'h3B + i), 8'h00);
      wr(8'(8'h3B + i), 8'hFF);
      rd(8'(8'h3B + i), 8'h3F);
    end
    wr(8'h3F, 8'hFF);
    rd(8'h3F, 8'h00);
    wr(8'h40, 8'hFF);
    rd(8'h40, 8'hE3);
    wr(8'h41, 8'hFF);
    rd(8'h41, 8'h9F);
    wr(8'h50, 8'h12);
    rd(8'h50, 8'h00);
    wr(8'h41, 8'h00);
  endtask

  task automatic t_dvs;
    logic [7:0] c [4];
    c = '{8'h00, 8'h15, 8'h2A, 8'h3F};
    for (int i = 0; i < 4; i++) wr(8'(8'h3B + i), c[i]);
    pair_sel = 5'h01;
    for (int s = 0; s < 4; s++) begin
      pins = {6'h00, s[0], s[1]};
      step(1);
      chk({2'h0, target}, c[s]);
    end
    pair_sel = 5'h1C;
    pins = 8'h80;
    step(1);
    chk({2'h0, target}, c[1]);
    base_code = 6'h11;
    pair_sel = 5'h00;
    step(1);
    chk({2'h0, target}, 8'h11);
    pair_sel = 5'h1E;
    base_code = 6'h12;
    step(1);
    chk({2'h0, target}, 8'h12);
    pair_sel = 5'h1D;
    ser_code = 6'h23;
    ser_valid = 1'b1;
    step(1);
    ser_valid = 1'b0;
    ser_code = 6'h05;
    step(1);
    chk({2'h0, target}, 8'h23);
    rd(8'h3F, 8'h23);
  endtask

  // One reset per strap: the slot is only captured after reset
  task automatic t_boot;
    for (int i = 0; i < 3; i++) begin
      boot = 4'h0;
      do_reset(3'(i + 2));
      rd(8'h40, {3'(i + 2), 5'h00});
      for (int k = 0; k < 3; k++) begin
        boot[k] = 1'b1;
        step(2);
        chk({7'h0, bb_en}, {7'h0, k >= i});
      end
    end
    boot = 4'hF;
    do_reset(3'h0);
    step(2);
    chk({7'h0, bb_en}, 8'h00);
    do_reset(3'h5);
    wr(8'h40, 8'h01);
    step(1);
    chk({7'h0, bb_en}, 8'h00);
  endtask

  task automatic t_enable;
    boot = 4'h7;
    do_reset(3'h7);
    wr(8'h40, 8'h01);
    step(1);
    chk({7'h0, bb_en}, 8'h00);
    boot[3] = 1'b1;
    step(2);
    chk({7'h0, bb_en}, 8'h01);
    mask = 8'h04;
    pins = 8'h04;
    wr(8'h40, 8'h02);
    step(1);
    chk({7'h0, bb_en}, 8'h01);
    pins = 8'hFB;
    step(2);
    chk({7'h0, bb_en}, 8'h00);
    wr(8'h40, 8'h03);
    pins = 8'h04;
    step(2);
    chk({7'h0, bb_en}, 8'h00);
    wr(8'h40, 8'h00);
    step(2);
    chk({6'h0, act, psv}, 8'h00);
    wr(8'h41, 8'h09);
    step(2);
    chk({6'h0, act, psv}, 8'h03);
    wr(8'h40, 8'h01);
    step(2);
    chk({5'h0, bb_en, act, psv}, 8'h04);
    wr(8'h41, 8'h00);
    hard_reset = 1'b1;
    step(2);
    chk({5'h0, bb_en, act, psv}, 8'h03);
    hard_reset = 1'b0;
    power_off = 1'b1;
    step(2);
    chk({5'h0, bb_en, act, psv}, 8'h02);
    power_off = 1'b0;
    wr(8'h41, 8'h92);
    chk({5'h0, tbl, slow, buck}, 8'h07);
    wr(8'h41, 8'h00);
    chk({5'h0, tbl, slow, buck}, 8'h00);
  endtask

  // Bounded wait for the ramped code; a spent bound ends the run
  task automatic wait_code(input code_t exp, output int n);
    n = 0;
    while (applied !== exp && n < 700) begin
      @(negedge clk);
      n++;
    end
    if (applied !== exp) begin
      chk({2'h0, applied}, {2'h0, exp});
      results();
    end
  endtask

  task automatic t_ramp;
    int n1;
    int n2;
    bb_set = 6'h05;
    step(2);
    chk({2'h0, applied}, 8'h05);
    wr(8'h41, 8'h04);
    bb_set = 6'h07;
    wait_code(6'h06, n1);
    chk({7'h0, n1 >= 499 && n1 <= 502}, 8'h01);
    wait_code(6'h07, n2);
    chk({7'h0, n2 == 500}, 8'h01);
    bb_set = 6'h02;
    step(1);
    chk({2'h0, applied}, 8'h02);
    wr(8'h41, 8'h00);
    bb_set = 6'h3F;
    step(1);
    chk({2'h0, applied}, 8'h3F);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    err_count = 0;
    n_compared = 0;
    reset_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    pins = 8'h00;
    pair_sel = 5'h00;
    mask = 8'h00;
    ser_valid = 1'b0;
    ser_code = 6'h00;
    base_code = 6'h00;
    strap = 3'h7;
    boot = 4'h0;
    hard_reset = 1'b0;
    power_off = 1'b0;
    bb_set = 6'h00;
    @(negedge clk);
    do_reset(3'h7);
    t_regs();
    t_dvs();
    t_boot();
    t_enable();
    t_ramp();
    results();
  end

endmodule
